/* File: bench/board_pins_model.sv */
/* board side: mode and special pins, sampled clocks, lock, aux wire.
   assumes bench requests and a pull-up on the aux line. */
`timescale 1ns/1ps
module board_pins_model (
    // requests
    input wire logic clk_sys_i,
    input wire logic [4:0] req_i,
    input wire logic lock_req_i,
    // pins to the decoder
    output logic [4:0] pins_o,
    output logic lock_o,
    // aux wire
    input wire logic aux_i,
    input wire logic aux_oe_i,
    output logic aux_line_o
);
    initial pins_o = 5'h0;
    initial lock_o = 1'b0;
    // pins move just after an edge, as a board driver would
    always @(posedge clk_sys_i) begin
        pins_o <= req_i;
        lock_o <= lock_req_i;
    end
    // a released open drain reads the pull-up, never the last value
    assign aux_line_o = aux_oe_i ? aux_i : 1'b1;
endmodule

/* File: bench/clock_mult_param_decode_assertions.sv */
/* port checker for the clock multiplier decoder.
   assumes clk_en_i high and the global word written over the bus. */
`timescale 1ns/1ps
module clk_mult_checker #(
    parameter int RATIO_W = 32,
    parameter int SETS = 4,
    parameter int SETTLE_CYC = 100
) (
    // clock, reset, bus
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    // pins
    input wire logic [1:0] mode_select_i,
    input wire logic special_function_pin_i,
    input wire logic syn_clk_i,
    input wire logic pll_locked_i,
    // outputs
    input wire logic clk_out_o,
    input wire logic clk_out_oe_o,
    input wire logic aux_out_oe_o,
    input wire logic [5:0] ratio_frac_bits_o,
    input wire logic [7:0] min_loop_bw_hz_o
);
    // shadow of the global word; checks wait until it has settled
    clk_mult_pkg::global_cfg_t g_q;
    logic wr_q;
    logic [2:0] age_q;
    wire ok = age_q > 3'h4;
    wire sp = special_function_pin_i;
    wire [2:0] pf = g_q.pin_function;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q <= 1'b0;
            age_q <= 3'h0;
            g_q <= '0;
        end else begin
            wr_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == 32'h8;
            if (wr_q) begin
                g_q <= hwdata_i[8:0];
                age_q <= 3'h1;
            end else if (age_q != 3'h0 && age_q != 3'h7) begin
                age_q <= age_q + 3'h1;
            end
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence held_s(x);
        x [*4];
    endsequence
    AST_BW: assert property (ok |-> min_loop_bw_hz_o == 8'h01 << g_q.min_loop_bw)
        else $error("bandwidth wrong");
    AST_FRAC: assert property (ok |-> ratio_frac_bits_o == (g_q.ratio_format ? 6'h14 : 6'h0c))
        else $error("fraction width wrong");
    AST_UNL_LOW: assert property ((ok && !g_q.out_during_unlock && !pll_locked_i) [*6]
        |-> !clk_out_o) else $error("clock not low while unlocked");
    AST_ON: assert property (ok && g_q.out_during_unlock && pf == 3'h3
        |-> clk_out_o == $past(syn_clk_i, 3)) else $error("clock not passed");
    AST_DIS_CLK: assert property (held_s(ok && sp && (pf == 3'h0 || pf == 3'h2))
        |-> !clk_out_oe_o) else $error("clock not disabled");
    AST_DIS_AUX: assert property (held_s(ok && sp && (pf == 3'h1 || pf == 3'h2))
        |-> !aux_out_oe_o) else $error("aux not disabled");
    AST_ENA: assert property (held_s(ok && !sp && pf == 3'h0 && g_q.out_during_unlock)
        |-> clk_out_oe_o) else $error("clock not enabled");
    AST_MODE: assert property (ok && !g_q.out_during_unlock && $changed(mode_select_i)
        |-> ##4 (!clk_out_o) [*2]) else $error("no loss of lock on mode change");
endmodule
bind clock_mult_param_decode clk_mult_checker #(
    .RATIO_W(RATIO_W),
    .SETS(SETS),
    .SETTLE_CYC(SETTLE_CYC)
) u_clk_mult_checker (
    .clk_sys_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
    .mode_select_i, .special_function_pin_i, .syn_clk_i, .pll_locked_i, .clk_out_o,
    .clk_out_oe_o, .aux_out_oe_o, .ratio_frac_bits_o, .min_loop_bw_hz_o
);

/* File: bench/tb.sv */
/* bench: drives bus and board model, predicts clock, aux, ratio, fraction and bandwidth outputs from settings.
   assumes one clock and a settle count of 4. */
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0;
    logic hw = 1'b0;
    logic [1:0] ht = 2'h0;
    logic [31:0] ha = 32'h0;
    logic [31:0] hd = 32'h0;
    logic [4:0] req = 5'h0;
    logic lreq = 1'b0;
    logic [4:0] pn;
    logic [31:0] hr, effr, rd, r;
    logic [31:0] rat [4];
    logic [15:0] mo;
    logic hrdy, hrsp, co, coe, ax, axe, axl, irq, lkp;
    logic [5:0] frac;
    logic [7:0] bwz;
    int errors = 0;
    int n_checks = 0;
    int seed = 32'h00efb59f;
    int pf, sp, md, st, oud, fmt, bw, rf, sy, lk, i;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    clock_mult_param_decode #(.SETTLE_CYC(4)) u_clock_mult_param_decode (
        .clk_sys_i, .reset_i, .clk_en_i(1'b1), .hsel_i(hsel), .haddr_i(ha), .htrans_i(ht),
        .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hd), .hready_i(hrdy), .hrdata_o(hr),
        .hreadyout_o(hrdy), .hresp_o(hrsp), .mode_select_i(pn[4:3]),
        .special_function_pin_i(pn[2]), .ref_clk_i(pn[1]), .syn_clk_i(pn[0]),
        .pll_locked_i(lkp), .clk_out_o(co), .clk_out_oe_o(coe), .aux_out_o(ax),
        .aux_out_oe_o(axe), .eff_ratio_o(effr), .ratio_frac_bits_o(frac),
        .min_loop_bw_hz_o(bwz), .irq_o(irq)
    );
    board_pins_model u_board_pins_model (
        .clk_sys_i, .req_i(req), .lock_req_i(lreq), .pins_o(pn), .lock_o(lkp),
        .aux_i(ax), .aux_oe_i(axe), .aux_line_o(axl)
    );
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {hsel, ht, ha, hw} <= {1'b1, 2'h2, a, w};
        @(posedge clk_sys_i);
        while (hrdy !== 1'b1) @(posedge clk_sys_i);
        {hsel, ht, hd} <= {1'b0, 2'h0, d};
        @(posedge clk_sys_i);
        while (hrdy !== 1'b1) @(posedge clk_sys_i);
        rd = hr;
    endtask
    task pins();
        req <= {md[1:0], sp[0], rf[0], sy[0]};
        lreq <= lk[0];
    endtask
    task expect_all();
        logic [3:0] m;
        logic dc, gt, ea, eo;
        int src;
        m = mo[md * 4 +: 4];
        dc = sp && (pf == 0 || pf == 2);
        gt = lk || oud;
        src = (pf == 7 && sp) ? 2 : m[1:0];
        eo = (src != 3 || !st || !lk) && !(sp && (pf == 1 || pf == 2));
        ea = src == 1 ? rf : src == 2 ? gt && sy : src == 3 && !st && !lk;
        chk("eff_ratio", (pf == 3 && sp) ? rat[md] >> (m[3:2] + 1) : rat[md], effr);
        chk("frac", fmt ? 20 : 12, frac);
        chk("bw_hz", 1 << bw, bwz);
        chk("clk_oe", !dc, coe);
        if (!dc) chk("clk_out", gt && sy, co);
        chk("aux_oe", eo, axe);
        if (eo) chk("aux", ea, axl);
    endtask
    task close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rat[i] = $random(seed);
            bus(1, 32'h10 + 4 * i, rat[i]);
            bus(0, 32'h10 + 4 * i, 32'h0);
            chk("ratio", rat[i], rd);
        end
        // every pin function, pin level, mode and style; the rest random
        for (i = 0; i < 128; i++) begin
            r = $random(seed);
            pf = i >> 4;
            sp = (i >> 3) & 1;
            md = (i >> 1) & 3;
            st = i & 1;
            // fields one by one: a concatenation of ints would leave them all zero
            mo = r[31:16];
            lk = r[7] | r[8];
            sy = r[6];
            rf = r[5];
            bw = r[4:2];
            oud = r[1];
            fmt = r[0];
            bus(1, 32'h8, {23'h0, st[0], oud[0], fmt[0], pf[2:0], bw[2:0]});
            bus(1, 32'hc, {16'h0, mo});
            pins();
            repeat (20) @(posedge clk_sys_i);
            expect_all();
        end
        bus(1, 32'h4, 32'h2);
        bus(0, 32'h0, 32'h0);
        md = (md + 1) & 3;
        pins();
        for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk_sys_i);
        chk("irq_set", 1, irq);
        bus(0, 32'h0, 32'h0);
        chk("mode_evt", 2, rd & 32'h2);
        bus(0, 32'h0, 32'h0);
        chk("evt_clear", 0, rd & 32'h2);
        chk("irq_clear", 0, irq);
        bus(1, 32'h4, 32'h0);
        md = (md + 1) & 3;
        pins();
        repeat (20) @(posedge clk_sys_i);
        chk("irq_masked", 0, irq);
        bus(1, 32'h28, r);
        bus(0, 32'h28, 32'h0);
        chk("unmapped", 0, rd);
        chk("hresp", 0, hrsp);
        close_out();
    end
endmodule

/* File: src/clk_mult_defines.svh */
/*
 clock multiplier configuration decoder: field codes and timing constants.
 assumes inclusion by bare name from the design file only.
*/
`ifndef CLK_MULT_DEFINES_SVH
`define CLK_MULT_DEFINES_SVH

`define AUX_SRC_RSVD 2'h0
`define AUX_SRC_REF 2'h1
`define AUX_SRC_SYN 2'h2
`define AUX_SRC_LOCK 2'h3

`define PINFN_DIS_CLK 3'h0
`define PINFN_DIS_AUX 3'h1
`define PINFN_DIS_BOTH 3'h2
`define PINFN_SHIFT_EN 3'h3
`define PINFN_FORCE_SYN 3'h7

`define STYLE_PUSH_PULL 1'h0
`define FMT_20_12 1'h0
`define FMT_FRAC_20_12 6'h0c
`define FMT_FRAC_12_20 6'h14
`define SHIFT_BASE 3'h1
`define BW_BASE_HZ 8'h01

`define MODE_SETTLE_NS 1000
`define CLK_PERIOD_NS 10
`define MODE_SETTLE_CYC ((`MODE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_STATUS 32'h0000_0000
`define REG_MASK 32'h0000_0004
`define REG_CFG_GLOBAL 32'h0000_0008
`define REG_SET_MODAL 32'h0000_000c
`define REG_RATIO_BASE 32'h0000_0010
`define REG_EFF_RATIO 32'h0000_0020
`define REG_STATE 32'h0000_0024

`define STAT_UNLOCK 0
`define STAT_MODE_CHG 1
`define STAT_LOCK 2

`endif

/* File: src/clk_mult_pkg.sv */
/*
 types for the clock multiplier configuration decoder.
 numeric codes stand as literals here; clk_mult_defines.svh is not included.
*/
package clk_mult_pkg;
    typedef struct packed {
        logic [1:0] shift_sel;
        logic [1:0] aux_src;
    } modal_set_t;

    typedef struct packed {
        logic unlock_style;
        logic out_during_unlock;
        logic ratio_format;
        logic [2:0] pin_function;
        logic [2:0] min_loop_bw;
    } global_cfg_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } ahb_addr_t;

    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_SETTLE = 2'b01,
        ST_UNLOCKED = 2'b10
    } lock_state_t;
endpackage

/* File: src/clock_mult_param_decode.sv */
/*
 configuration decoder of a fractional-n clock multiplier: modal sets, user
 ratios and global settings held in registers standing in for one-time memory,
 reached over ahb-lite; pins pass two flops before use.
 assumes the analog loop reports lock on pll_locked_i and clocks arrive as
 sampled levels in the clk_sys_i domain.
*/
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "clk_mult_defines.svh"

// Functional notes
// - four modal sets stored; the two mode pins pick the active one
// - shift select codes 00..11 shift the ratio right by one to four
// - shift only when special pin high and pin function is 011
// - aux source 01 reference, 10 synthesized clock, 11 lock status, 00 reserved
// - four 32-bit user ratios, indexed by the active modal set
// - style 0: aux push-pull, high while unlocked, low while locked
// - style 1: aux open drain, low while unlocked, released while locked
// - style bit ignored while aux carries a clock
// - output-during-unlock 0: clock output and synthesized clock on aux held low while unlocked; reference clock on aux keeps running
// - output-during-unlock 1: clock outputs stay enabled while unlocked
// - format bit 0 means 20.12, 1 means 12.20
// - pin function 000/001/010: special pin disables clock, aux, or both
// - pin function 011 makes special pin the shift enable; 100..110 reserved
// - pin function 111 lets special pin force aux source to synthesized clock
// - bandwidth code gives 1 Hz at 000 doubling to 128 Hz at 111
// - special pin low enables selected outputs, high disables them
// - aux override only while special pin high, else stored source
// - any mode pin change causes a temporary loss of lock
module clock_mult_param_decode #(
    parameter int RATIO_W = 32,
    parameter int SETS = 4,
    parameter int SETTLE_CYC = `MODE_SETTLE_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // board pins and analog loop status
    input wire logic [1:0] mode_select_i,
    input wire logic special_function_pin_i,
    input wire logic ref_clk_i,
    input wire logic syn_clk_i,
    input wire logic pll_locked_i,
    // outputs
    output logic clk_out_o,
    output logic clk_out_oe_o,
    output logic aux_out_o,
    output logic aux_out_oe_o,
    output logic [RATIO_W-1:0] eff_ratio_o,
    output logic [5:0] ratio_frac_bits_o,
    output logic [7:0] min_loop_bw_hz_o,
    output logic irq_o
);
    localparam logic [15:0] SETTLE_N = 16'(SETTLE_CYC);

    // pin synchronisers, first stage read only by the second
    logic [5:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end else if (clk_en_i) begin
            pin_s1_q <= {mode_select_i, special_function_pin_i, ref_clk_i, syn_clk_i,
                pll_locked_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire logic [1:0] mode_sel = pin_s2_q[5:4];
    wire logic sp_pin = pin_s2_q[3];
    wire logic ref_clk = pin_s2_q[2];
    wire logic syn_clk = pin_s2_q[1];
    wire logic pll_lock = pin_s2_q[0];

    // configuration storage
    clk_mult_pkg::modal_set_t modal_q [SETS];
    logic [RATIO_W-1:0] ratio_q [SETS];
    clk_mult_pkg::global_cfg_t glob_q;
    logic [2:0] stat_q, mask_q;

    // ahb address phase capture
    clk_mult_pkg::ahb_addr_t aph_q;
    wire logic take = hsel_i & hready_i & htrans_i[1];
    wire logic wr_dp = aph_q.hsel & aph_q.hwrite;
    wire logic rd_take = take & ~hwrite_i;
    wire logic [31:0] wa = aph_q.haddr;
    wire logic wr_glob = wr_dp & (wa == `REG_CFG_GLOBAL);
    wire logic wr_mask = wr_dp & (wa == `REG_MASK);
    wire logic wr_modal = wr_dp & (wa == `REG_SET_MODAL);
    wire logic rd_stat = rd_take & (haddr_i == `REG_STATUS);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            aph_q <= '0;
        end else if (clk_en_i && hready_i) begin
            aph_q <= '{htrans: htrans_i, haddr: haddr_i, hwrite: hwrite_i,
                hsize: hsize_i, hsel: take};
        end
    end

    // four stored sets and ratios, one generate entry each
    for (genvar g = 0; g < SETS; g++) begin : g_set
        wire logic wr_ratio = wr_dp & (wa == `REG_RATIO_BASE + 32'(4 * g));
        always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
                modal_q[g] <= '0;
                ratio_q[g] <= '0;
            end else if (clk_en_i) begin
                if (wr_modal) begin
                    modal_q[g] <= hwdata_i[4*g +: 4];
                end
                if (wr_ratio) begin
                    ratio_q[g] <= hwdata_i[RATIO_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            glob_q <= '0;
            mask_q <= 3'h0;
        end else if (clk_en_i) begin
            if (wr_glob) begin
                glob_q <= hwdata_i[8:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata_i[2:0];
            end
        end
    end

    // active set and decode
    clk_mult_pkg::modal_set_t act;
    assign act = modal_q[mode_sel];
    wire logic [RATIO_W-1:0] ratio_raw = ratio_q[mode_sel];
    wire logic [2:0] pfn = glob_q.pin_function;
    wire logic shift_en = sp_pin & (pfn == `PINFN_SHIFT_EN);
    wire logic [2:0] shift_n = 3'({1'b0, act.shift_sel} + `SHIFT_BASE);
    wire logic [RATIO_W-1:0] ratio_eff = shift_en ? ratio_raw >> shift_n : ratio_raw;
    wire logic force_syn = sp_pin & (pfn == `PINFN_FORCE_SYN);
    wire logic [1:0] aux_src = force_syn ? `AUX_SRC_SYN : act.aux_src;
    wire logic clk_dis = sp_pin & ((pfn == `PINFN_DIS_CLK) | (pfn == `PINFN_DIS_BOTH));
    wire logic aux_dis = sp_pin & ((pfn == `PINFN_DIS_AUX) | (pfn == `PINFN_DIS_BOTH));

    // lock tracking: a mode change forces an unlock while the new set settles
    clk_mult_pkg::lock_state_t st_q, st_d;
    logic [1:0] mode_prev_q;
    logic [15:0] cnt_q;
    wire logic mode_chg = mode_sel != mode_prev_q;
    wire logic settle_done = cnt_q >= SETTLE_N - 16'h0001;
    always_comb begin
        st_d = st_q;
        case (st_q)
            clk_mult_pkg::ST_LOCKED: begin
                if (mode_chg) st_d = clk_mult_pkg::ST_SETTLE;
                else if (!pll_lock) st_d = clk_mult_pkg::ST_UNLOCKED;
            end
            clk_mult_pkg::ST_SETTLE: begin
                if (mode_chg) st_d = clk_mult_pkg::ST_SETTLE;
                else if (settle_done) st_d = pll_lock ? clk_mult_pkg::ST_LOCKED
                    : clk_mult_pkg::ST_UNLOCKED;
            end
            clk_mult_pkg::ST_UNLOCKED: begin
                if (mode_chg) st_d = clk_mult_pkg::ST_SETTLE;
                else if (pll_lock) st_d = clk_mult_pkg::ST_LOCKED;
            end
            default: st_d = clk_mult_pkg::ST_UNLOCKED;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_q <= clk_mult_pkg::ST_UNLOCKED;
            mode_prev_q <= 2'h0;
            cnt_q <= 16'h0000;
        end else if (clk_en_i) begin
            st_q <= st_d;
            mode_prev_q <= mode_sel;
            cnt_q <= (mode_chg || st_q != clk_mult_pkg::ST_SETTLE) ? 16'h0000
                : cnt_q + 16'h0001;
        end
    end
    wire logic locked = st_q == clk_mult_pkg::ST_LOCKED;

    // output muxing
    wire logic gate_ok = locked | glob_q.out_during_unlock;
    wire logic clk_val = syn_clk & gate_ok;
    wire logic clk_oe = ~clk_dis;
    logic aux_val, aux_oe;
    always_comb begin
        aux_val = 1'b0;
        aux_oe = ~aux_dis;
        case (aux_src)
            `AUX_SRC_REF: aux_val = ref_clk;
            `AUX_SRC_SYN: aux_val = clk_val;
            `AUX_SRC_LOCK: begin
                if (glob_q.unlock_style == `STYLE_PUSH_PULL) begin
                    aux_val = ~locked;
                end else begin
                    aux_val = 1'b0;
                    aux_oe = ~aux_dis & ~locked;
                end
            end
            default: aux_val = 1'b0; // reserved source drives a quiet low
        endcase
    end
    // reserved pin functions 100..110 disable nothing and shift nothing
    wire logic [5:0] frac_bits = (glob_q.ratio_format == `FMT_20_12) ? `FMT_FRAC_20_12
        : `FMT_FRAC_12_20;
    wire logic [7:0] bw_hz = `BW_BASE_HZ << glob_q.min_loop_bw;

    // status events, sticky, set wins over read-clear
    wire logic [2:0] ev;
    assign ev[`STAT_UNLOCK] = locked & (st_d != clk_mult_pkg::ST_LOCKED);
    assign ev[`STAT_MODE_CHG] = mode_chg;
    assign ev[`STAT_LOCK] = ~locked & (st_d == clk_mult_pkg::ST_LOCKED);
    wire logic [2:0] stat_d = (rd_stat ? 3'h0 : stat_q) | ev;

    // read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (haddr_i)
            `REG_STATUS: rdata = {29'h0, stat_q};
            `REG_MASK: rdata = {29'h0, mask_q};
            `REG_CFG_GLOBAL: rdata = {23'h0, glob_q};
            `REG_SET_MODAL: rdata = {16'h0, modal_q[3], modal_q[2], modal_q[1], modal_q[0]};
            `REG_RATIO_BASE: rdata = 32'(ratio_q[0]);
            `REG_RATIO_BASE + 32'h4: rdata = 32'(ratio_q[1]);
            `REG_RATIO_BASE + 32'h8: rdata = 32'(ratio_q[2]);
            `REG_RATIO_BASE + 32'hc: rdata = 32'(ratio_q[3]);
            `REG_EFF_RATIO: rdata = 32'(ratio_eff);
            `REG_STATE: rdata = {27'h0, locked, mode_sel, sp_pin, shift_en};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stat_q <= 3'h0;
            hrdata_o <= 32'h0000_0000;
            clk_out_o <= 1'b0;
            clk_out_oe_o <= 1'b0;
            aux_out_o <= 1'b0;
            aux_out_oe_o <= 1'b0;
            eff_ratio_o <= '0;
            ratio_frac_bits_o <= 6'h00;
            min_loop_bw_hz_o <= 8'h00;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            stat_q <= stat_d;
            if (rd_take) begin
                hrdata_o <= rdata;
            end
            clk_out_o <= clk_val;
            clk_out_oe_o <= clk_oe;
            aux_out_o <= aux_val;
            aux_out_oe_o <= aux_oe;
            eff_ratio_o <= ratio_eff;
            ratio_frac_bits_o <= frac_bits;
            min_loop_bw_hz_o <= bw_hz;
            irq_o <= |(stat_d & mask_q);
        end
    end
    // zero wait states and always okay, so these are constant flops
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (clk_en_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
endmodule
